// ===== pkg/rcc_consts.svh
// Constants for the register and instruction core.
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
`define RCC_RESET_VEC 16'hfffe
`define RCC_SR_C      0
`define RCC_SR_Z      1
`define RCC_SR_N      2
`define RCC_SR_V      8
`define RCC_R_PC      4'h0
`define RCC_R_SP      4'h1
`define RCC_R_SR      4'h2
`define RCC_R_CG      4'h3
`define RCC_OP_MOV    4'h4
`define RCC_OP_ADD    4'h5
`define RCC_OP_ADDC   4'h6
`define RCC_OP_SUBC   4'h7
`define RCC_OP_SUB    4'h8
`define RCC_OP_CMP    4'h9
`define RCC_OP_DADD   4'ha
`define RCC_OP_BIT    4'hb
`define RCC_OP_BIC    4'hc
`define RCC_OP_BIS    4'hd
`define RCC_OP_XOR    4'he
`define RCC_OP_AND    4'hf
`define RCC_SO_RRC    3'h0
`define RCC_SO_SWPB   3'h1
`define RCC_SO_RRA    3'h2
`define RCC_SO_SXT    3'h3
`define RCC_SO_PUSH   3'h4
`define RCC_SO_CALL   3'h5
`endif

// ===== pkg/rcc_pkg.sv
// Types shared by the register and instruction core.
package rcc_pkg;
   typedef enum logic [2:0] {
      rcc_st_boot,
      rcc_st_vec,
      rcc_st_decode,
      rcc_st_src_idx,
      rcc_st_src_dat,
      rcc_st_dst_idx,
      rcc_st_dst_dat,
      rcc_st_wb
   } rcc_state_t;

   typedef struct packed {
      logic [15:0] res;
      logic        c;
      logic        z;
      logic        n;
      logic        v;
      logic        wr_res;
      logic        wr_flg;
   } rcc_alu_t;
endpackage

// ===== core/rcc_core.sv
// Sixteen-register RISC core: sequencer, decoder, ALU and memory bus master.
`timescale 1ns/100ps
`include "rcc_consts.svh"
module rcc_core #(
   parameter int NUM_REGS = 16
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic             mem_byte
);
   if (NUM_REGS != 16) begin : g_chk
      $error("rcc_core supports exactly sixteen registers.");
   end

   // -----------------------------------------------------------------
   // Decode and ALU helpers
   // -----------------------------------------------------------------
   function automatic logic msb(input logic [15:0] v, input logic bw);
      return bw ? v[7] : v[15];
   endfunction

   // Base of an indexed address: symbolic uses the extension word address.
   function automatic logic [15:0] ea_base(input logic [3:0] n, input logic [15:0] rv);
      if (n == `RCC_R_PC) return rv - 16'h0002;
      if (n == `RCC_R_SR) return 16'h0000;
      return rv;
   endfunction

   function automatic rcc_pkg::rcc_alu_t alu_dual(input logic [3:0] op, input logic bw,
                                                  input logic [15:0] a_in,
                                                  input logic [15:0] b_in, input logic cin);
      rcc_pkg::rcc_alu_t o;
      logic [15:0] m;
      logic [15:0] a;
      logic [15:0] b;
      logic [16:0] s;
      logic        ci;
      logic        sa;
      o = '0;
      m = bw ? 16'h00ff : 16'hffff;
      a = a_in & m;
      b = b_in & m;
      ci = cin;
      if (op == `RCC_OP_SUB || op == `RCC_OP_SUBC || op == `RCC_OP_CMP) begin
         a = ~a & m;
      end
      if (op == `RCC_OP_SUB || op == `RCC_OP_CMP) begin
         ci = 1'b1;
      end
      if (op == `RCC_OP_ADD || op == `RCC_OP_DADD) begin
         ci = 1'b0;
      end
      s = {1'b0, b} + {1'b0, a} + {16'h0000, ci};
      sa = msb(a, bw);
      o.wr_res = 1'b1;
      o.wr_flg = 1'b1;
      case (op)
         `RCC_OP_MOV: begin
            o.res = a;
            o.wr_flg = 1'b0;
         end
         `RCC_OP_BIT, `RCC_OP_AND: begin
            o.res = a & b;
            o.wr_res = (op == `RCC_OP_AND);
         end
         `RCC_OP_BIC: begin
            o.res = ~a & b;
            o.wr_flg = 1'b0;
         end
         `RCC_OP_BIS: begin
            o.res = a | b;
            o.wr_flg = 1'b0;
         end
         `RCC_OP_XOR: begin
            o.res = a ^ b;
            o.v = sa & msb(b, bw);
         end
         default: begin
            o.res = s[15:0];
            o.c = bw ? s[8] : s[16];
            o.v = (sa == msb(b, bw)) && (msb(s[15:0], bw) != sa);
            o.wr_res = (op != `RCC_OP_CMP);
         end
      endcase
      o.res = o.res & m;
      o.z = (o.res == 16'h0000);
      o.n = msb(o.res, bw);
      if (op == `RCC_OP_BIT || op == `RCC_OP_AND || op == `RCC_OP_XOR) begin
         o.c = ~o.z;
      end
      return o;
   endfunction

   function automatic rcc_pkg::rcc_alu_t alu_single(input logic [2:0] op, input logic bw,
                                                    input logic [15:0] x, input logic cin);
      rcc_pkg::rcc_alu_t o;
      o = '0;
      o.wr_res = 1'b1;
      o.wr_flg = 1'b1;
      o.c = x[0];
      case (op)
         `RCC_SO_RRC: o.res = bw ? {8'h00, cin, x[7:1]} : {cin, x[15:1]};
         `RCC_SO_RRA: o.res = bw ? {8'h00, x[7], x[7:1]} : {x[15], x[15:1]};
         `RCC_SO_SWPB: begin
            o.res = {x[7:0], x[15:8]};
            o.wr_flg = 1'b0;
         end
         `RCC_SO_SXT: o.res = {{8{x[7]}}, x[7:0]};
         default: begin
            o.wr_res = 1'b0;
            o.wr_flg = 1'b0;
         end
      endcase
      o.z = (o.res == 16'h0000);
      o.n = msb(o.res, bw && op != `RCC_SO_SXT);
      if (op == `RCC_SO_SXT) begin
         o.c = ~o.z;
      end
      return o;
   endfunction

   // -----------------------------------------------------------------
   // State and decode
   // -----------------------------------------------------------------
   rcc_pkg::rcc_state_t state;
   logic [15:0]         regs [16];
   logic [15:0]         ir;
   logic [15:0]         sval;
   logic [15:0]         ea;

   logic [15:0]         insn;
   logic                is_jump;
   logic                is_single;
   logic                is_dual;
   logic [3:0]          src_n;
   logic [3:0]          dst_n;
   logic [1:0]          as_m;
   logic                bw;
   logic                ad;
   logic                cg_hit;
   logic [15:0]         cg_val;
   logic                src_direct;
   logic [15:0]         opnd_s;
   logic [15:0]         opnd_d;
   logic [15:0]         pc;
   logic [15:0]         sp_dec;
   logic                jump_taken;
   logic                fin;
   rcc_pkg::rcc_alu_t   alu;

   assign insn      = (state == rcc_pkg::rcc_st_decode) ? mem_rdata : ir;
   assign is_jump   = (insn[15:13] == 3'b001);
   assign is_single = (insn[15:10] == 6'b000100);
   assign is_dual   = (insn[15:12] >= `RCC_OP_MOV);
   assign src_n     = is_dual ? insn[11:8] : insn[3:0];
   assign dst_n     = insn[3:0];
   assign as_m      = insn[5:4];
   assign bw        = insn[6];
   assign ad        = insn[7] & is_dual;
   assign pc        = regs[`RCC_R_PC];
   assign sp_dec    = regs[`RCC_R_SP] - 16'h0002;

   // Constants come from decode alone, so common values cost no fetch cycle.
   assign cg_hit = (src_n == `RCC_R_CG) || (src_n == `RCC_R_SR && as_m[1]);
   always_comb begin
      cg_val = 16'h0000;
      if (src_n == `RCC_R_SR) begin
         cg_val = as_m[0] ? 16'h0008 : 16'h0004;
      end else begin
         case (as_m)
            2'b01:   cg_val = 16'h0001;
            2'b10:   cg_val = 16'h0002;
            2'b11:   cg_val = 16'hffff;
            default: cg_val = 16'h0000;
         endcase
      end
   end

   assign src_direct = (as_m == 2'b00) || cg_hit;

   always_comb begin
      if (state == rcc_pkg::rcc_st_src_dat) begin
         opnd_s = mem_rdata;
      end else if (state == rcc_pkg::rcc_st_decode) begin
         opnd_s = cg_hit ? cg_val : regs[src_n];
      end else begin
         opnd_s = sval;
      end
   end
   assign opnd_d = (state == rcc_pkg::rcc_st_dst_dat) ? mem_rdata : regs[dst_n];

   assign alu = is_dual ? alu_dual(insn[15:12], bw, opnd_s, opnd_d, regs[`RCC_R_SR][`RCC_SR_C])
      : alu_single(insn[9:7], bw, opnd_s, regs[`RCC_R_SR][`RCC_SR_C]);

   always_comb begin
      case (insn[12:10])
         3'h0:    jump_taken = ~regs[`RCC_R_SR][`RCC_SR_Z];
         3'h1:    jump_taken = regs[`RCC_R_SR][`RCC_SR_Z];
         3'h2:    jump_taken = ~regs[`RCC_R_SR][`RCC_SR_C];
         3'h3:    jump_taken = regs[`RCC_R_SR][`RCC_SR_C];
         3'h4:    jump_taken = regs[`RCC_R_SR][`RCC_SR_N];
         3'h5:    jump_taken = ~(regs[`RCC_R_SR][`RCC_SR_N] ^ regs[`RCC_R_SR][`RCC_SR_V]);
         3'h6:    jump_taken = regs[`RCC_R_SR][`RCC_SR_N] ^ regs[`RCC_R_SR][`RCC_SR_V];
         default: jump_taken = 1'b1;
      endcase
   end

   // Source operand is in hand and no destination memory access remains.
   assign fin = (state == rcc_pkg::rcc_st_decode && !is_jump && src_direct && !ad) ||
                (state == rcc_pkg::rcc_st_src_dat && !ad);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ir <= 16'h0000;
         sval <= 16'h0000;
      end else begin
         if (state == rcc_pkg::rcc_st_decode) begin
            ir <= mem_rdata;
         end
         if (state == rcc_pkg::rcc_st_decode || state == rcc_pkg::rcc_st_src_dat) begin
            sval <= opnd_s;
         end
      end
   end

   // -----------------------------------------------------------------
   // Sequencer, register file and bus requests
   // -----------------------------------------------------------------
   // Reads are answered combinationally in the cycle they are presented, which
   // lets the next fetch overlap a register operation without a bubble.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= rcc_pkg::rcc_st_boot;
         mem_addr <= 16'h0000;
         mem_wdata <= 16'h0000;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_byte <= 1'b0;
         ea <= 16'h0000;
         for (int i = 0; i < 16; i++) begin
            regs[i] <= 16'h0000;
         end
      end else begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_byte <= 1'b0;
         if (fin) begin
            if (is_single && insn[9:7] == `RCC_SO_PUSH) begin
               regs[`RCC_R_SP] <= sp_dec;
               mem_addr <= sp_dec;
               mem_wdata <= bw ? {8'h00, opnd_s[7:0]} : opnd_s;
               mem_wr <= 1'b1;
               mem_byte <= bw;
               state <= rcc_pkg::rcc_st_wb;
            end else if (is_single && insn[9:7] == `RCC_SO_CALL) begin
               regs[`RCC_R_SP] <= sp_dec;
               mem_addr <= sp_dec;
               mem_wdata <= pc;
               mem_wr <= 1'b1;
               regs[`RCC_R_PC] <= opnd_s;
               state <= rcc_pkg::rcc_st_wb;
            end else if (is_single && !src_direct) begin
               mem_addr <= ea;
               mem_wdata <= alu.res;
               mem_wr <= alu.wr_res;
               mem_byte <= bw;
               if (alu.wr_flg) begin
                  regs[`RCC_R_SR] <= {regs[`RCC_R_SR][15:9], alu.v, regs[`RCC_R_SR][7:3],
                                      alu.n, alu.z, alu.c};
               end
               state <= rcc_pkg::rcc_st_wb;
            end else begin
               if (alu.wr_flg) begin
                  regs[`RCC_R_SR] <= {regs[`RCC_R_SR][15:9], alu.v, regs[`RCC_R_SR][7:3],
                                      alu.n, alu.z, alu.c};
               end
               if (alu.wr_res && dst_n != `RCC_R_CG) begin
                  regs[dst_n] <= alu.res;
               end
               mem_addr <= (alu.wr_res && dst_n == `RCC_R_PC) ? alu.res : pc;
               regs[`RCC_R_PC] <= ((alu.wr_res && dst_n == `RCC_R_PC) ? alu.res : pc)
                                  + 16'h0002;
               mem_rd <= 1'b1;
               state <= rcc_pkg::rcc_st_decode;
            end
         end else begin
            case (state)
               rcc_pkg::rcc_st_boot: begin
                  mem_addr <= `RCC_RESET_VEC;
                  mem_rd <= 1'b1;
                  state <= rcc_pkg::rcc_st_vec;
               end
               rcc_pkg::rcc_st_vec, rcc_pkg::rcc_st_wb: begin
                  mem_addr <= (state == rcc_pkg::rcc_st_vec) ? mem_rdata : pc;
                  regs[`RCC_R_PC] <= ((state == rcc_pkg::rcc_st_vec) ? mem_rdata : pc)
                                     + 16'h0002;
                  mem_rd <= 1'b1;
                  state <= rcc_pkg::rcc_st_decode;
               end
               rcc_pkg::rcc_st_decode: begin
                  if (is_jump) begin
                     mem_addr <= jump_taken ? pc + {{5{insn[9]}}, insn[9:0], 1'b0} : pc;
                     regs[`RCC_R_PC] <= (jump_taken ? pc + {{5{insn[9]}}, insn[9:0], 1'b0}
                                         : pc) + 16'h0002;
                     mem_rd <= 1'b1;
                  end else if (src_direct || as_m == 2'b01) begin
                     // Indexed source, or register or constant source with indexed destination.
                     mem_addr <= pc;
                     regs[`RCC_R_PC] <= pc + 16'h0002;
                     mem_rd <= 1'b1;
                     state <= src_direct ? rcc_pkg::rcc_st_dst_idx
                                         : rcc_pkg::rcc_st_src_idx;
                  end else begin
                     mem_addr <= regs[src_n];
                     ea <= regs[src_n];
                     mem_rd <= 1'b1;
                     mem_byte <= bw;
                     if (as_m[0]) begin
                        regs[src_n] <= regs[src_n] + ((bw && src_n > `RCC_R_SP) ?
                                                      16'h0001 : 16'h0002);
                     end
                     state <= rcc_pkg::rcc_st_src_dat;
                  end
               end
               rcc_pkg::rcc_st_src_idx, rcc_pkg::rcc_st_dst_idx: begin
                  mem_addr <= mem_rdata + ea_base(
                     (state == rcc_pkg::rcc_st_src_idx) ? src_n : dst_n,
                     (state == rcc_pkg::rcc_st_src_idx) ? regs[src_n] : regs[dst_n]);
                  ea <= mem_rdata + ea_base(
                     (state == rcc_pkg::rcc_st_src_idx) ? src_n : dst_n,
                     (state == rcc_pkg::rcc_st_src_idx) ? regs[src_n] : regs[dst_n]);
                  mem_rd <= 1'b1;
                  mem_byte <= bw;
                  state <= (state == rcc_pkg::rcc_st_src_idx) ? rcc_pkg::rcc_st_src_dat
                                                              : rcc_pkg::rcc_st_dst_dat;
               end
               rcc_pkg::rcc_st_src_dat: begin
                  mem_addr <= pc;
                  regs[`RCC_R_PC] <= pc + 16'h0002;
                  mem_rd <= 1'b1;
                  state <= rcc_pkg::rcc_st_dst_idx;
               end
               rcc_pkg::rcc_st_dst_dat: begin
                  mem_addr <= ea;
                  mem_wdata <= alu.res;
                  mem_wr <= alu.wr_res;
                  mem_byte <= bw;
                  if (alu.wr_flg) begin
                     regs[`RCC_R_SR] <= {regs[`RCC_R_SR][15:9], alu.v, regs[`RCC_R_SR][7:3],
                                         alu.n, alu.z, alu.c};
                  end
                  state <= rcc_pkg::rcc_st_wb;
               end
               default: state <= rcc_pkg::rcc_st_boot;
            endcase
         end
      end
   end
endmodule

// ===== verif/rcc_core_assertions.sv
// Concurrent checks on the bus ports of the register and instruction core.
`timescale 1ns/100ps
module rcc_core_assertions #(
   parameter int NUM_REGS = 16
) (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        mem_byte
);
   // ---------------------------------------------------------------
   // Edge counter since reset release
   // ---------------------------------------------------------------
   logic [1:0] boot_cnt;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         boot_cnt <= 2'h0;
      end else if (boot_cnt != 2'h3) begin
         boot_cnt <= boot_cnt + 2'h1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // ---------------------------------------------------------------
   // Opcode shapes seen on the fetch data
   // ---------------------------------------------------------------
   // Patterns are narrow on purpose: data words never carry these values in the bench.
   sequence reg_add_fetch;
      mem_rd && !mem_byte && mem_rdata[15:12] == 4'h5 && !mem_rdata[7] &&
         mem_rdata[5:4] == 2'h0 && mem_rdata[11:8] >= 4'h4 && mem_rdata[3:0] >= 4'h4;
   endsequence
   sequence const_fetch;
      mem_rd && !mem_byte && mem_rdata[15:12] >= 4'h4 && mem_rdata[11:8] == 4'h3 &&
         mem_rdata[5:4] != 2'h0 && !mem_rdata[7] && mem_rdata[3:0] >= 4'h4;
   endsequence
   sequence abs_store_fetch;
      mem_rd && !mem_byte && mem_rdata[15:12] == 4'h4 && mem_rdata[7] &&
         mem_rdata[5:0] == 6'h02 && mem_rdata[11:8] >= 4'h4;
   endsequence
   sequence call_fetch;
      mem_rd && !mem_byte && mem_rdata == 16'h12b0;
   endsequence
   sequence push_fetch;
      mem_rd && !mem_byte && mem_rdata[15:4] == 12'h120;
   endsequence

   rd_wr_excl_a: assert property (!(mem_rd && mem_wr))
      else $error("read and write requested together");
   vec_fetch_a: assert property (boot_cnt == 2'h1 |-> mem_rd && mem_addr == 16'hfffe)
      else $error("reset vector not read first");
   first_fetch_a: assert property (
      boot_cnt == 2'h2 |-> mem_rd && mem_addr == $past(mem_rdata))
      else $error("first fetch not at vector value");
   byte_wdata_a: assert property (mem_wr && mem_byte |-> mem_wdata[15:8] == 8'h00)
      else $error("byte write carries a high byte");
   reg_op_a: assert property (
      reg_add_fetch |=> mem_rd && !mem_wr && mem_addr == $past(mem_addr) + 16'h2)
      else $error("register operation took more than one cycle");
   const_gen_a: assert property (
      const_fetch |=> mem_rd && mem_addr == $past(mem_addr) + 16'h2)
      else $error("constant source caused a memory access");
   abs_store_a: assert property (
      abs_store_fetch |=> mem_rd ##1 (mem_rd && mem_addr == $past(mem_rdata))
      ##1 (mem_wr && mem_addr == $past(mem_addr))
      ##1 (mem_rd && mem_addr == $past(mem_addr, 4) + 16'h4))
      else $error("absolute store sequence wrong");
   call_seq_a: assert property (
      call_fetch |=> (mem_rd && mem_addr == $past(mem_addr) + 16'h2)
      ##1 (mem_wr && mem_wdata == $past(mem_addr) + 16'h2)
      ##1 (mem_rd && mem_addr == $past(mem_rdata, 2)))
      else $error("call did not push return and jump");
   push_seq_a: assert property (
      push_fetch |=> (mem_wr && !mem_byte)
      ##1 (mem_rd && mem_addr == $past(mem_addr, 2) + 16'h2))
      else $error("push sequence wrong");
endmodule

bind rcc_core rcc_core_assertions #(.NUM_REGS(NUM_REGS)) u_rcc_core_assertions (
   .clock(clock), .reset_n(reset_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte));

// ===== verif/rcc_mem_model.sv
// Zero-wait memory standing on the core's shared bus.
`timescale 1ns/100ps
module rcc_mem_model (
   input  wire logic        clock,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic [15:0]      mem_rdata,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic        mem_byte
);
   logic [15:0] mem [0:32767];
   logic [15:0] last;
   logic [15:0] word;

   // Outside a read the bus shows the inverse of the last value, so stale data never matches.
   always_comb begin
      word = mem[mem_addr[15:1]];
      if (!mem_rd) begin
         mem_rdata = ~last;
      end else if (mem_byte) begin
         mem_rdata = mem_addr[0] ? {~word[15:8], word[15:8]} : {~word[7:0], word[7:0]};
      end else begin
         mem_rdata = word;
      end
   end

   always_ff @(posedge clock) begin
      if (mem_rd) begin
         last <= mem_rdata;
      end
   end

   // A plain process owns the array, so the bench may preload it between runs.
   always @(posedge clock) begin
      if (mem_wr && mem_byte && mem_addr[0]) begin
         mem[mem_addr[15:1]][15:8] <= mem_wdata[7:0];
      end else if (mem_wr && mem_byte) begin
         mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
      end else if (mem_wr) begin
         mem[mem_addr[15:1]] <= mem_wdata;
      end
   end
endmodule

// ===== verif/tb.sv
// Self-checking bench: runs a small program and checks every bus write.
`timescale 1ns/100ps
module tb;
   logic        clock;
   logic        reset_n;
   logic [15:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [15:0] mem_rdata;
   logic        mem_rd;
   logic        mem_wr;
   logic        mem_byte;
   logic [15:0] pc;
   logic [32:0] exp_q[$];
   int          err_total;
   int          total_checks;

   rcc_core #(.NUM_REGS(16)) u_rcc_core (
      .clock(clock), .reset_n(reset_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte));
   rcc_mem_model u_rcc_mem_model (
      .clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte));

   always #5 clock = ~clock;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic put(input logic [15:0] w);
      u_rcc_mem_model.mem[pc[15:1]] = w;
      pc = pc + 16'h2;
   endtask

   task automatic put2(input logic [15:0] w0, input logic [15:0] w1);
      put(w0);
      put(w1);
   endtask

   task automatic expect_wr(input logic [15:0] a, input logic [15:0] d, input logic b);
      exp_q.push_back({a, d, b});
   endtask

   task automatic check_wr(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Operands keep their top nibble away from the opcodes the checker watches for.
   task automatic load_prog(input logic [15:0] a, input logic [15:0] b);
      for (int i = 0; i < 32768; i++) begin
         u_rcc_mem_model.mem[i] = 16'h0000;
      end
      u_rcc_mem_model.mem[16'h7fff] = 16'hf000;
      pc = 16'hf000;
      put2(16'h4031, 16'h0300);
      put2(16'h4034, a);
      put2(16'h4035, b);
      put(16'h5405);
      put2(16'h4582, 16'h0200);
      expect_wr(16'h0200, a + b, 1'b0);
      put2(16'h44c2, 16'h0205);
      expect_wr(16'h0205, {8'h00, a[7:0]}, 1'b1);
      put(16'h4337);
      put2(16'h4782, 16'h0206);
      expect_wr(16'h0206, 16'hffff, 1'b0);
      put(16'h5327);
      put2(16'h4782, 16'h0208);
      expect_wr(16'h0208, 16'h0001, 1'b0);
      put2(16'h9404, 16'h2002);
      put2(16'h4482, 16'h020a);
      expect_wr(16'h020a, a, 1'b0);
      put2(16'h9405, 16'h2002);
      put2(16'h4482, 16'h020c);
      put2(16'h4582, 16'h020e);
      expect_wr(16'h020e, a + b, 1'b0);
      put(16'h1205);
      expect_wr(16'h02fe, a + b, 1'b0);
      put(16'h12b0);
      put(pc + 16'h4);
      expect_wr(16'h02fc, pc, 1'b0);
      put(16'h3fff);
      put2(16'h4182, 16'h0210);
      expect_wr(16'h0210, 16'h02fc, 1'b0);
      put(16'h3fff);
   endtask

   // ---------------------------------------------------------------
   // Write monitor
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      if (reset_n === 1'b1 && mem_wr === 1'b1) begin
         if (exp_q.size() == 0) begin
            check_wr({mem_addr, mem_wdata, mem_byte}, 33'h0);
         end else begin
            check_wr({mem_addr, mem_wdata, mem_byte}, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (2000) @(posedge clock);
      err_total++;
      print_verdict();
   end

   initial begin
      logic [15:0] ra;
      logic [15:0] rb;
      clock = 1'b0;
      reset_n = 1'b0;
      err_total = 0;
      total_checks = 0;
      void'($urandom(21247));
      for (int run = 0; run < 2; run++) begin
         @(posedge clock);
         reset_n <= 1'b0;
         ra = {4'h0, 12'($urandom())};
         rb = {4'h2, 11'($urandom()), 1'b1};
         @(posedge clock);
         load_prog(ra, rb);
         repeat (7) @(posedge clock);
         reset_n <= 1'b1;
         for (int i = 0; i < 300 && exp_q.size() != 0; i++) begin
            @(posedge clock);
         end
         if (exp_q.size() != 0) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
         end
         repeat (10) @(posedge clock);
      end
      print_verdict();
   end
endmodule
